// >>> verification/adc_host_if_tb.sv
// Bench: host model drives the device; a queue model predicts every word read.
// Assumes default conversion clock divide and edge count from the package.
module adc_host_if_tb
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic              conversion_start_strobe;
  host_pins_t        host;
  logic [DATA_W-1:0] sample_a, sample_b, data_out, config_word, w;
  logic              busy, hold, data_oe_n, oe;
  int                err_count = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                n;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] last = 12'h000;
  logic [DATA_W-1:0] last_a = 12'h000;
  always #5 core_clk = ~core_clk;
  adc_host_if u_adc_host_if (.core_clk(core_clk), .rst(rst),
    .conversion_start_strobe(conversion_start_strobe), .host(host), .sample_a(sample_a),
    .sample_b(sample_b), .busy(busy), .hold(hold), .data_out(data_out),
    .data_oe_n(data_oe_n), .config_word(config_word));
  host_model u_host_model (.core_clk(core_clk), .data_out(data_out),
    .data_oe_n(data_oe_n), .conversion_start_strobe(conversion_start_strobe), .host(host));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One conversion; a second start while busy must change nothing
  task automatic conv(input logic twice);
    sample_a = DATA_W'($urandom);
    sample_b = DATA_W'($urandom);
    u_host_model.start_conv();
    chk(DATA_W'({busy, hold}), 12'h003);
    n = 0;
    if (twice)
    begin
      @(negedge core_clk);
      u_host_model.start_conv();
      n = 3;
    end
    while (busy === 1'b1 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(DATA_W'(n >= (CONV_EDGES - 1) * CLK_DIV && n <= CONV_EDGES * CLK_DIV + 2), 12'h001);
    chk(DATA_W'(hold), 12'h000);
    // Store plus output stage hold one pair beyond the depth; a full one drops the pair
    if ((q.size() + 1) / 2 <= FIFO_DEPTH)
    begin
      q.push_back(sample_a);
      q.push_back(sample_b);
    end
  endtask
  // Empty queue: the A word of the last pair is read again
  task automatic rdchk();
    if (q.size() > 0)
    begin
      last = q.pop_front();
      if (q.size() % 2 == 1)
        last_a = last;
    end
    else
      last = last_a;
    u_host_model.rd_word(1'b0, w, oe);
    chk(w, last);
    chk(DATA_W'(oe), 12'h000);
  endtask
  // Hang guard, well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      summarize();
    end
  end
  initial
  begin
    sample_a = 12'h000;
    sample_b = 12'h000;
    void'($urandom(88));
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    chk(DATA_W'({busy, hold, data_oe_n}), 12'h001);
    chk(config_word, 12'h000);
    conv(1'b1);
    repeat (3) rdchk();
    repeat (FIFO_DEPTH + 1) conv(1'b0);
    u_host_model.rd_word(1'b1, w, oe);
    chk(DATA_W'(oe), 12'h001);
    repeat (2 * FIFO_DEPTH + 1) rdchk();
    w = DATA_W'($urandom);
    u_host_model.wr_word(1'b0, w);
    chk(config_word, w);
    u_host_model.wr_word(1'b1, ~w);
    chk(config_word, w);
    repeat (6)
    begin
      conv(1'($urandom_range(1)));
      repeat ($urandom_range(3)) rdchk();
    end
    summarize();
  end
endmodule

// >>> verification/host_model.sv
// Host model: start strobe, chip select, read and write strobes, two-way bus.
// Assumes calls come at falling clock edges, from one bench process.
module host_model
  import adc_ctrl_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe_n,
  output logic                   conversion_start_strobe,
  output host_pins_t             host
);
  timeunit 1ns;
  timeprecision 1ps;
  logic              cs    = 1'b1;
  logic              rd    = 1'b1;
  logic              wr    = 1'b1;
  logic              wr_on = 1'b0;
  logic [DATA_W-1:0] drv   = 12'h5a5;
  logic [DATA_W-1:0] wdat  = 12'h000;
  initial conversion_start_strobe = 1'b1;
  // Released bus flips every cycle so a stale word never looks valid
  always @(posedge core_clk) drv <= ~drv;
  // Wire level: device word only while it enables its drivers
  assign host = {cs, rd, wr, (!data_oe_n ? data_out : (wr_on ? wdat : drv))};
  // Strobe held low two cycles, then high again
  task automatic start_conv();
    conversion_start_strobe = 1'b0;
    repeat (2) @(negedge core_clk);
    conversion_start_strobe = 1'b1;
  endtask
  // Read: answer taken at the next falling edge, where it has settled, then released
  task automatic rd_word(input logic cs_v, output logic [DATA_W-1:0] w, output logic o);
    cs = cs_v;
    rd = 1'b0;
    @(negedge core_clk);
    w  = data_out;
    o  = data_oe_n;
    rd = 1'b1;
    @(negedge core_clk);
    cs = 1'b1;
    @(negedge core_clk);
  endtask
  // Write: data stands across the rising strobe and two cycles after
  task automatic wr_word(input logic cs_v, input logic [DATA_W-1:0] v);
    cs    = cs_v;
    wr_on = 1'b1;
    wdat  = v;
    wr    = 1'b0;
    repeat (2) @(negedge core_clk);
    wr = 1'b1;
    repeat (2) @(negedge core_clk);
    wr_on = 1'b0;
    cs    = 1'b1;
  endtask
endmodule

// >>> verilog/adc_ctrl_pkg.sv
// Package: shared constants and carriers for the dual converter host interface.
// Assumes one core clock at 100 MHz; the converter clock is an enable pulse.
package adc_ctrl_pkg;
  localparam int DATA_W         = 12;   // Parallel bus width
  localparam int CONV_EDGES     = 14;   // Converter clock edges until busy falls
  localparam int CLK_DIV        = 4;    // Core cycles per converter clock edge
  localparam int FIFO_DEPTH     = 8;    // Result pairs buffered in the store
  localparam logic [11:0] CFG_RESET = 12'h000;

  // One finished conversion: a word from each converter
  typedef struct packed {
    logic [DATA_W-1:0] res_a;
    logic [DATA_W-1:0] res_b;
  } result_pair_t;

  // Host pin group as seen by the device
  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [DATA_W-1:0] data_in;
  } host_pins_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_HOLD   = 2'b01,
    ST_CONV   = 2'b10
  } conv_state_t;
endpackage

// >>> verilog/adc_host_if.sv
// Control and parallel host interface of a dual 12-bit sampling converter.
// Assumes host pins are synchronous to core_clk; analog core is modelled by inputs.
// Notes on behaviour
// - Busy rises as soon as the sample-and-hold stages are in hold.
// - Busy falls once the running conversion is finished.
// - A falling start strobe puts both converters into hold at once, whatever the clock.
// - The conversion proper starts on the first converter clock edge after that.
// - The parallel interface is used only while chip select is low.
// - With chip select high the strobes are ignored and the data bus is released.
// - A falling read strobe puts the next result word on the data bus.
// - A read edge counts only with chip select low.
// - Bus data is captured on the rising write strobe.
// - A write edge counts only with chip select low.
// - Busy falls after the 14th converter clock edge of the conversion.
module adc_host_if
  import adc_ctrl_pkg::*;
#(
  parameter int DIV   = CLK_DIV,
  parameter int EDGES = CONV_EDGES
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              conversion_start_strobe,
  input  wire host_pins_t        host,
  input  wire logic [DATA_W-1:0] sample_a,
  input  wire logic [DATA_W-1:0] sample_b,
  output logic                   busy,
  output logic                   hold,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_n,
  output logic [DATA_W-1:0]      config_word
);
  conv_state_t      st_r, st_nxt;
  logic [7:0]       div_r, div_nxt;
  logic [4:0]       edge_r, edge_nxt;
  logic             cst_d_r, rd_d_r, wr_d_r;
  logic             busy_r, busy_nxt, hold_r, hold_nxt;
  logic             sel_b_r, sel_b_nxt, oe_n_r, oe_n_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt, cfg_r, cfg_nxt;
  logic             clk_en, start_fall, rd_fall, wr_rise, push, pop, f_valid;
  result_pair_t     f_out, f_in;

  // Converter clock enable from the core clock
  always_comb
  begin
    clk_en  = (div_r == 8'(DIV - 1));
    div_nxt = clk_en ? 8'h00 : div_r + 8'h01;
  end

  // Edge detection on the host strobes; read and write gated by chip select
  always_comb
  begin
    start_fall = cst_d_r && !conversion_start_strobe;
    rd_fall    = rd_d_r && !host.rd_n && !host.cs_n;
    wr_rise    = !wr_d_r && host.wr_n && !host.cs_n;
  end

  // Conversion sequencer
  always_comb
  begin
    st_nxt   = st_r;
    edge_nxt = edge_r;
    busy_nxt = busy_r;
    hold_nxt = hold_r;
    push     = 1'b0;
    unique case (st_r)
      ST_SAMPLE:
        if (start_fall)
        begin
          st_nxt   = ST_HOLD;
          hold_nxt = 1'b1;
          busy_nxt = 1'b1;
        end
      ST_HOLD:
        if (clk_en)
        begin
          st_nxt   = ST_CONV;
          edge_nxt = 5'h01;
        end
      ST_CONV:
        if (clk_en)
        begin
          if (edge_r == 5'(EDGES - 1))
          begin
            st_nxt   = ST_SAMPLE;
            busy_nxt = 1'b0;
            hold_nxt = 1'b0;
            push     = 1'b1;
          end
          else
            edge_nxt = edge_r + 5'h01;
        end
      default:
        st_nxt = ST_SAMPLE;
    endcase
  end

  // Read side: each falling read with a pair buffered gives the next word, A then B of a pair
  always_comb
  begin
    pop       = 1'b0;
    sel_b_nxt = sel_b_r;
    dout_nxt  = dout_r;
    oe_n_nxt  = host.cs_n | host.rd_n;
    if (rd_fall)
    begin
      dout_nxt  = sel_b_r ? f_out.res_b : f_out.res_a;
      sel_b_nxt = f_valid ? !sel_b_r : sel_b_r;
      pop       = f_valid && sel_b_r;
    end
    cfg_nxt = wr_rise ? host.data_in : cfg_r;
  end

  // Registers only; every next value but the three strobe delays is worked out above
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r    <= ST_SAMPLE;
      div_r   <= '0;
      edge_r  <= '0;
      busy_r  <= 1'b0;
      hold_r  <= 1'b0;
      cst_d_r <= 1'b1;
      rd_d_r  <= 1'b1;
      wr_d_r  <= 1'b1;
      sel_b_r <= 1'b0;
      oe_n_r  <= 1'b1;
      dout_r  <= '0;
      cfg_r   <= CFG_RESET;
    end
    else
    begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      edge_r  <= edge_nxt;
      busy_r  <= busy_nxt;
      hold_r  <= hold_nxt;
      cst_d_r <= conversion_start_strobe;
      rd_d_r  <= host.rd_n;
      wr_d_r  <= host.wr_n;
      sel_b_r <= sel_b_nxt;
      oe_n_r  <= oe_n_nxt;
      dout_r  <= dout_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  // Both results enter the buffer together as one pair
  assign f_in.res_a  = sample_a;
  assign f_in.res_b  = sample_b;
  // Outputs come straight from their registers
  assign busy        = busy_r;
  assign hold        = hold_r;
  assign data_out    = dout_r;
  assign data_oe_n   = oe_n_r;
  assign config_word = cfg_r;

  // A full FIFO drops the newest pair; the host must keep up with reads
  result_fifo #(.WIDTH(2*DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_out)
  );

  // Sequencer and bus checks
  a_busy_rise: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_SAMPLE && start_fall) |=> busy)
    else $error("busy not raised after start");
  a_hold_now: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_SAMPLE && start_fall) |=> hold)
    else $error("hold not entered");
  a_conv_start: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_HOLD && clk_en) |=> st_r == ST_CONV)
    else $error("conversion did not start");
  a_busy_fall: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_CONV && clk_en && edge_r == 5'(EDGES - 1)) |=> !busy)
    else $error("busy did not fall");
  a_busy_ends: assert property (@(posedge core_clk) disable iff (rst)
    $fell(busy) |-> st_r == ST_SAMPLE)
    else $error("busy fell early");
  a_cs_release: assert property (@(posedge core_clk) disable iff (rst)
    host.cs_n |=> data_oe_n)
    else $error("bus driven with cs high");
  a_rd_gate: assert property (@(posedge core_clk) disable iff (rst)
    host.cs_n |=> $stable(data_out))
    else $error("read acted with cs high");
  a_wr_gate: assert property (@(posedge core_clk) disable iff (rst)
    host.cs_n |=> $stable(config_word))
    else $error("write acted with cs high");
  a_wr_take: assert property (@(posedge core_clk) disable iff (rst)
    wr_rise |=> config_word == $past(host.data_in))
    else $error("write data not captured");

  // Busy stays up through every conversion step but the last
  a_busy_stays: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_CONV && !(clk_en && edge_r == 5'(EDGES - 1))) |=> busy)
    else $error("busy dropped during conversion");
  // A start edge while waiting for the first clock must not restart anything
  a_start_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_HOLD && start_fall) |=> (hold && busy))
    else $error("start accepted while busy");
  // A read with chip select low turns the bus drivers on
  a_rd_drive: assert property (@(posedge core_clk) disable iff (rst)
    rd_fall |=> !data_oe_n)
    else $error("bus not driven after read");
  // The second word of a pair releases it from the buffer
  a_pair_pop: assert property (@(posedge core_clk) disable iff (rst)
    (rd_fall && f_valid && sel_b_r) |=> !sel_b_r)
    else $error("pair not advanced after second word");
  // Edge counter never runs past its count
  a_edge_bound: assert property (@(posedge core_clk) disable iff (rst)
    (st_r == ST_CONV) |-> (edge_r < 5'(EDGES)))
    else $error("conversion ran past its edge count");
endmodule

// >>> verilog/result_fifo.sv
// Result FIFO: parameterised width and depth, valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
module result_fifo
  import adc_ctrl_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
)(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] out_r, out_nxt;
  logic             ov_r, ov_nxt;
  logic             push, load, take_mem, take_in, store;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = ov_r;
  assign out_data  = out_r;

  // Output register refills whenever it is empty or being taken
  // An empty store hands the incoming word straight through whenever the output register refills, so no cycle is lost
  always_comb
  begin
    push     = in_valid && in_ready;
    load     = !ov_r || out_ready;
    take_mem = load && (cnt_r != '0);
    take_in  = load && (cnt_r == '0) && push;
    store    = push && !take_in;
    wp_nxt   = store ? wp_r + AW'(1) : wp_r;
    rp_nxt   = take_mem ? rp_r + AW'(1) : rp_r;
    cnt_nxt  = cnt_r + (AW+1)'(store) - (AW+1)'(take_mem);
    out_nxt  = take_mem ? mem_r[rp_r] : (take_in ? in_data : out_r);
    ov_nxt   = (take_mem || take_in) ? 1'b1 : (out_ready ? 1'b0 : ov_r);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      ov_r  <= 1'b0;
      out_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r  <= ov_nxt;
      out_r <= out_nxt;
    end
    if (store)
      mem_r[wp_r] <= in_data;
  end
endmodule
